// *** inc/asd_params.svh ***
// Register offsets, field positions, reset values and masks of the setup and diagnostic bank
`ifndef ASD_PARAMS_SVH
`define ASD_PARAMS_SVH

// Register indices (six-bit serial address)
`define ASD_ADDR_STATUS    6'h00
`define ASD_ADDR_CTRL      6'h01
`define ASD_ADDR_FAULT     6'h06
`define ASD_ADDR_DIAG_EN   6'h07
`define ASD_ADDR_TALLY     6'h08
`define ASD_ADDR_CHAN_LO   6'h09
`define ASD_ADDR_CFG_BASE  6'h19
`define ASD_ADDR_CFG_LAST  6'h20
`define ASD_ADDR_FILT0     6'h28
`define ASD_ADDR_FILT_BASE 6'h20
`define ASD_ADDR_FILT_LO   6'h21
`define ASD_ADDR_OFF_BASE  6'h29
`define ASD_ADDR_OFF_LAST  6'h30
`define ASD_ADDR_GAIN_BASE 6'h31
`define ASD_ADDR_LAST      6'h38

// Reset values
`define ASD_CTRL_RST       16'h0000
`define ASD_FAULT_RST      24'h000000
`define ASD_DIAG_EN_RST    24'h000040
`define ASD_TALLY_RST      8'h00
`define ASD_CFG_RST        16'h0860
`define ASD_FILT_RST       24'h060180
`define ASD_OFF_RST        24'h800000

// Writable bits of the control, setup, filter and diagnostic enable registers, and the fault bits that can be set
`define ASD_CTRL_WMASK     16'h1fff
`define ASD_CFG_WMASK      16'h0fff
`define ASD_FILT_WMASK     24'hff07ff
`define ASD_DIAG_EN_WMASK  24'h7ffffe
`define ASD_FAULT_MASK     24'h0ffafe

// Command byte and field positions
`define ASD_CMD_BITS       6'd8
`define ASD_BIT_IGNORE     6
`define ASD_BIT_SCLK_CNT   5
`define ASD_BIT_READ       4
`define ASD_BIT_WRITE      3
`define ASD_BIT_TALLY_EN   22
`define ASD_STATUS_ERR_BIT 6

// Register widths in bits
`define ASD_W8             5'd8
`define ASD_W16            5'd16
`define ASD_W24            5'd24

`endif

// *** inc/asd_pkg.sv ***
// Types shared by the setup and diagnostic register bank
`include "asd_params.svh"

package asd_pkg;

  typedef struct packed {
    logic [3:0] zero;
    logic       bipolar;
    logic [1:0] burnout;
    logic       pos_vref_buffer_on;
    logic       neg_vref_buffer_on;
    logic       pos_input_buffer_on;
    logic       neg_input_buffer_on;
    logic [1:0] ref_sel;
    logic [2:0] pga;
  } asd_cfg_s;

  typedef struct packed {
    logic [2:0]  filter_type;
    logic [3:0]  post_filter;
    logic        single_cycle;
    logic [4:0]  zero;
    logic [10:0] output_rate_word;
  } asd_filt_s;

  typedef struct packed {
    logic [2:0] zero;
    logic       ready_delay_bit;
    logic       cont_read;
    logic       data_status;
    logic       cs_en;
    logic       ref_en;
    logic [1:0] power_mode;
    logic [3:0] op_mode;
    logic [1:0] clk_sel;
  } asd_ctrl_s;

  typedef struct packed {
    logic       write_gate;
    logic       read;
    logic [5:0] target_reg_index;
  } asd_cmd_s;

  // Data length of each register on the serial link
  function automatic logic [4:0] reg_bits(input logic [5:0] a);
    logic [4:0] w;
    w = `ASD_W24;
    if (a == `ASD_ADDR_STATUS || a == 6'h05 || a == `ASD_ADDR_TALLY) begin
      w = `ASD_W8;
    end else if (a == `ASD_ADDR_CTRL || a == 6'h04) begin
      w = `ASD_W16;
    end else if (a >= `ASD_ADDR_CHAN_LO && a <= `ASD_ADDR_CFG_LAST) begin
      w = `ASD_W16;
    end
    return w;
  endfunction

endpackage

// *** verification/asd_host.sv ***
// Host side of the serial link: mode 3 frames with a 32 ns link clock
`timescale 1ns/1ps

module asd_host (
  // Serial link
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_din,
  input  wire logic spi_dout
);
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_din  = 1'b0;
  end

  // Drive on the falling edge, take read data on the rising edge
  task automatic bit_out(input logic b, output logic r);
    spi_sclk = 1'b0;
    spi_din  = b;
    #16;
    spi_sclk = 1'b1;
    r = spi_dout;
    #16;
  endtask

  task automatic xfer(input logic [1:0] gr, input logic [5:0] a, input int w,
                      input logic [23:0] wd, input int extra, output logic [23:0] rv);
    logic [7:0] cmd;
    logic       r;
    cmd = {gr, a};
    rv  = 24'h0;
    #5 spi_cs_n = 1'b0;
    #20;
    for (int i = 7; i >= 0; i--) bit_out(cmd[i], r);
    // Device fetches the read word in the system clock domain
    #250;
    for (int i = w - 1; i >= 0; i--) begin
      bit_out(wd[i], r);
      rv = {rv[22:0], r};
    end
    for (int i = 0; i < extra; i++) bit_out(~spi_din, r);
    // Released line must not keep the last bit
    spi_din = ~spi_din;
    #160 spi_cs_n = 1'b1;
    #160;
  endtask
endmodule

// *** verification/asd_regs_sva.sv ***
// Concurrent checks on the ports of the setup and diagnostic register bank
`timescale 1ns/1ps

module asd_regs_chk #(
  parameter logic [23:0] GAIN_TRIM = 24'h500000
) (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst,
  // Channel, calibration and diagnostic inputs
  input wire logic [2:0]         active_setup,
  input wire logic               cal_offset_load,
  input wire logic               cal_gain_load,
  input wire logic [2:0]         cal_setup,
  input wire logic [23:0]        cal_value,
  input wire logic               serial_blocked,
  // Settings out
  input asd_pkg::asd_ctrl_s      ctrl,
  input asd_pkg::asd_filt_s      sel_filt,
  input wire logic [23:0]        sel_offset,
  input wire logic [23:0]        sel_gain,
  input wire logic [23:0]        diag_enables,
  input wire logic               fault_summary
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration loads aimed at the setup currently selected
  sequence s_off_cal;
    (cal_offset_load && cal_setup == active_setup) ##1 $stable(active_setup);
  endsequence
  sequence s_gain_cal;
    (cal_gain_load && cal_setup == active_setup) ##1 $stable(active_setup);
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_rst_ctrl: assert property ($fell(rst) |-> ctrl == 16'h0000)
    else $error("control not cleared by reset");
  a_rst_diag: assert property ($fell(rst) |-> diag_enables == 24'h000040)
    else $error("diagnostic enables wrong after reset");
  a_rst_offset: assert property ($fell(rst) |-> sel_offset == 24'h800000)
    else $error("offset coefficient wrong after reset");
  a_rst_filter: assert property ($fell(rst) |-> sel_filt == 24'h060180)
    else $error("filter setting wrong after reset");
  a_rst_gain: assert property ($fell(rst) |-> sel_gain == GAIN_TRIM)
    else $error("gain coefficient wrong after reset");
  a_cal_offset: assert property (s_off_cal |=> sel_offset == $past(cal_value, 2))
    else $error("zero-scale load not seen on offset");
  a_cal_gain: assert property (s_gain_cal |=> sel_gain == $past(cal_value, 2))
    else $error("full-scale load not seen on gain");
  a_blocked_sum: assert property ((serial_blocked && diag_enables[6]) |-> ##[1:3] fault_summary)
    else $error("blocked interface not summarised");
endmodule

// *** verification/testbench.sv ***
// Self-checking bench of the setup and diagnostic register bank
`timescale 1ns/1ps
`include "asd_params.svh"

`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module testbench;
  localparam logic [23:0] TRIM = 24'h5a3c17; // Arbitrary trim value
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               spi_sclk, spi_cs_n, spi_din, spi_dout, spi_dout_oe;
  logic [2:0]         active_setup = 3'h0;
  logic               cal_offset_load = 1'b0;
  logic               cal_gain_load = 1'b0;
  logic [2:0]         cal_setup = 3'h0;
  logic [23:0]        cal_value = 24'h0;
  logic               serial_blocked = 1'b0;
  logic [23:0]        diag_evt = 24'h0;
  asd_pkg::asd_ctrl_s ctrl;
  asd_pkg::asd_cfg_s  sel_cfg;
  asd_pkg::asd_filt_s sel_filt;
  logic [23:0]        sel_offset, sel_gain, diag_enables, rv, w;
  logic               fault_summary;
  logic [23:0]        ecfg[8], efilt[8], eoff[8], egain[8];
  int                 n_fail = 0;
  int                 n_compared = 0;
  int                 cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  asd_regs #(.GAIN_TRIM(TRIM), .NSETUP(8)) uut (
    .clk_sys(clk_sys), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
    .active_setup(active_setup), .cal_offset_load(cal_offset_load),
    .cal_gain_load(cal_gain_load), .cal_setup(cal_setup), .cal_value(cal_value),
    .serial_blocked(serial_blocked), .diag_evt(diag_evt), .ctrl(ctrl),
    .sel_cfg(sel_cfg), .sel_filt(sel_filt), .sel_offset(sel_offset),
    .sel_gain(sel_gain), .diag_enables(diag_enables), .fault_summary(fault_summary));

  asd_host host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_din(spi_din),
                 .spi_dout(spi_dout));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic rd(input logic [5:0] a, input int n, output logic [23:0] v);
    host.xfer(2'b01, a, n, 24'h0, 0, v);
  endtask
  task automatic wr(input logic [5:0] a, input int n, input logic [23:0] v);
    logic [23:0] d;
    host.xfer(2'b00, a, n, v, 0, d);
  endtask
  function automatic logic [23:0] masked(input logic [23:0] d, input logic [23:0] m);
    return d & m;
  endfunction
  function automatic logic [5:0] filt_addr(input int s);
    return (s == 0) ? `ASD_ADDR_FILT0 : 6'(`ASD_ADDR_FILT_BASE + s);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    w = $urandom(32'hd76b);
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK(ctrl, 16'h0000)
    `CHK(diag_enables, 24'h000040)
    `CHK(sel_filt, 24'h060180)
    `CHK(sel_offset, 24'h800000)
    `CHK(sel_gain, TRIM)
    rd(`ASD_ADDR_TALLY, 8, rv);
    `CHK(rv, 24'h0)
    `CHK(spi_dout_oe, 1'b0)
    rd(6'h30, 24, rv);
    `CHK(rv, 24'h800000)
    rd(6'h24, 24, rv);
    `CHK(rv, 24'h060180)
    // Independent groups, with all-ones and all-zero corners
    for (int s = 0; s < 8; s++) begin
      w = (s == 0) ? 24'hffffff : (s == 7) ? 24'h0 : 24'($urandom());
      ecfg[s] = masked({8'h0, w[15:0]}, 24'(`ASD_CFG_WMASK));
      efilt[s] = masked(~w, `ASD_FILT_WMASK);
      eoff[s] = w ^ 24'h5a5a5a;
      egain[s] = ~w;
      wr(6'(`ASD_ADDR_CFG_BASE + s), 16, {8'h0, w[15:0]});
      wr(filt_addr(s), 24, ~w);
      wr(6'(`ASD_ADDR_OFF_BASE + s), 24, eoff[s]);
      wr(6'(`ASD_ADDR_GAIN_BASE + s), 24, egain[s]);
    end
    for (int s = 7; s >= 0; s--) begin
      @(posedge clk_sys);
      active_setup <= 3'(s);
      rd(6'(`ASD_ADDR_CFG_BASE + s), 16, rv);
      `CHK(rv, ecfg[s])
      rd(filt_addr(s), 24, rv);
      `CHK(rv, efilt[s])
      rd(6'(`ASD_ADDR_OFF_BASE + s), 24, rv);
      `CHK(rv, eoff[s])
      rd(6'(`ASD_ADDR_GAIN_BASE + s), 24, rv);
      `CHK(rv, egain[s])
      `CHK(sel_cfg, ecfg[s][15:0])
      `CHK(sel_filt, efilt[s])
      `CHK({sel_offset, sel_gain}, {eoff[s], egain[s]})
    end
    // Every gain, reference and coding choice on setup 0
    for (int i = 0; i < 8; i++) begin
      w = 24'(i);
      wr(`ASD_ADDR_CFG_BASE, 16, {12'h0, w[0], 6'h0, w[1:0], w[2:0]});
      `CHK(sel_cfg.pga, w[2:0])
      `CHK(sel_cfg.ref_sel, w[1:0])
      `CHK(sel_cfg.bipolar, w[0])
    end
    // Every power and operating mode
    for (int i = 0; i < 16; i++) begin
      w = masked(24'($urandom()), 24'(`ASD_CTRL_WMASK));
      w[5:2] = 4'(i);
      w[7:6] = 2'(i);
      wr(`ASD_ADDR_CTRL, 16, w);
      `CHK(ctrl, w[15:0])
      `CHK(ctrl.power_mode, 2'(i))
    end
    rd(`ASD_ADDR_CTRL, 16, rv);
    `CHK(rv, w)
    // A raised write gate voids the whole frame
    host.xfer(2'b10, `ASD_ADDR_CTRL, 16, 24'h000555, 0, rv);
    `CHK(ctrl, w[15:0])
    // Read-only places keep their contents
    wr(`ASD_ADDR_FAULT, 24, 24'hffffff);
    wr(`ASD_ADDR_TALLY, 8, 24'h0000ff);
    rd(`ASD_ADDR_TALLY, 8, rv);
    `CHK(rv, 24'h0)
    rd(`ASD_ADDR_FAULT, 24, rv);
    `CHK(rv, 24'h0)
    // Blocked interface drops writes and raises its flag
    @(posedge clk_sys);
    serial_blocked <= 1'b1;
    wr(`ASD_ADDR_CTRL, 16, 24'h000aaa);
    `CHK(ctrl, w[15:0])
    `CHK(fault_summary, 1'b1)
    rd(`ASD_ADDR_FAULT, 24, rv);
    `CHK(rv, 24'h000040)
    @(posedge clk_sys);
    serial_blocked <= 1'b0;
    repeat (6) @(posedge clk_sys);
    `CHK(fault_summary, 1'b0)
    // Access checks, clock count and external events
    wr(`ASD_ADDR_DIAG_EN, 24, 24'h000278);
    `CHK(diag_enables, 24'h000278)
    rd(6'h3a, 24, rv);
    rd(6'h00, 8, rv);
    `CHK(rv, 24'h000040)
    rd(`ASD_ADDR_FAULT, 24, rv);
    `CHK(rv, 24'h000010)
    wr(6'h3f, 24, 24'h123456);
    rd(`ASD_ADDR_FAULT, 24, rv);
    `CHK(rv, 24'h000008)
    host.xfer(2'b01, `ASD_ADDR_CTRL, 16, 24'h0, 1, rv);
    rd(`ASD_ADDR_FAULT, 24, rv);
    `CHK(rv, 24'h000020)
    @(posedge clk_sys);
    diag_evt <= 24'h000a00;
    @(posedge clk_sys);
    diag_evt <= 24'h0;
    repeat (4) @(posedge clk_sys);
    `CHK(fault_summary, 1'b1)
    rd(`ASD_ADDR_FAULT, 24, rv);
    `CHK(rv, 24'h000200)
    // Calibration loads on the selected setup
    @(posedge clk_sys);
    active_setup <= 3'h5;
    cal_setup <= 3'h5;
    cal_value <= 24'h3c0f81;
    cal_offset_load <= 1'b1;
    @(posedge clk_sys);
    cal_offset_load <= 1'b0;
    cal_value <= 24'h61e2d4;
    cal_gain_load <= 1'b1;
    @(posedge clk_sys);
    cal_gain_load <= 1'b0;
    rd(6'(`ASD_ADDR_OFF_BASE + 5), 24, rv);
    `CHK(rv, 24'h3c0f81)
    rd(6'(`ASD_ADDR_GAIN_BASE + 5), 24, rv);
    `CHK(rv, 24'h61e2d4)
    // Master clock tally runs once its enable is set
    wr(`ASD_ADDR_DIAG_EN, 24, 24'h400000);
    rd(`ASD_ADDR_TALLY, 8, rv);
    `CHK(rv != 24'h0, 1'b1)
    final_report();
  end
endmodule

bind asd_regs asd_regs_chk #(.GAIN_TRIM(GAIN_TRIM)) chk (
  .clk_sys(clk_sys), .rst(rst), .active_setup(active_setup),
  .cal_offset_load(cal_offset_load), .cal_gain_load(cal_gain_load),
  .cal_setup(cal_setup), .cal_value(cal_value), .serial_blocked(serial_blocked),
  .ctrl(ctrl), .sel_filt(sel_filt), .sel_offset(sel_offset), .sel_gain(sel_gain),
  .diag_enables(diag_enables), .fault_summary(fault_summary));

// *** verilog/asd_regs.sv ***
// Setup, diagnostic and converter control register bank with its serial front end
`timescale 1ns/1ps
`include "asd_params.svh"

module asd_regs #(
  parameter logic [23:0] GAIN_TRIM = 24'h500000,
  parameter int          NSETUP    = 8
) (
  // System clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Serial link
  input  wire logic                 spi_sclk,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_din,
  output logic                      spi_dout,
  output logic                      spi_dout_oe,
  // Channel and calibration logic
  input  wire logic [2:0]           active_setup,
  input  wire logic                 cal_offset_load,
  input  wire logic                 cal_gain_load,
  input  wire logic [2:0]           cal_setup,
  input  wire logic [23:0]          cal_value,
  // Diagnostic sources
  input  wire logic                 serial_blocked,
  input  wire logic [23:0]          diag_evt,
  // Settings to the converter core
  output asd_pkg::asd_ctrl_s        ctrl,
  output asd_pkg::asd_cfg_s         sel_cfg,
  output asd_pkg::asd_filt_s        sel_filt,
  output logic [23:0]               sel_offset,
  output logic [23:0]               sel_gain,
  output logic [23:0]               diag_enables,
  output logic                      fault_summary
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: deserialiser, runs only while the frame is open

  logic [5:0]        bit_cnt_ff;
  logic [23:0]       shift_ff;
  asd_pkg::asd_cmd_s cmd_ff;
  logic              cmd_done_ff;
  logic              data_done_ff;
  logic              over_ff;
  logic [23:0]       wr_data_ff;
  logic              dout_ff;
  logic              dout_oe_ff;
  logic [4:0]        cmd_bits;
  logic [5:0]        last_bit;
  logic [4:0]        out_idx;
  logic [4:0]        data_pos;

  // Sys-domain read word, held still while the link shifts it out
  logic [23:0]       rd_hold_ff;

  assign cmd_bits = asd_pkg::reg_bits(cmd_ff.target_reg_index);
  assign last_bit = `ASD_CMD_BITS - 6'd1 + {1'b0, cmd_bits};
  assign data_pos = bit_cnt_ff[4:0] - 5'd8;
  assign out_idx  = cmd_bits - 5'd1 - data_pos;

  // Frame state dies with chip select, the link clock may stop at any time
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_ff   <= 6'h00;
      shift_ff     <= 24'h000000;
      cmd_ff       <= '0;
      cmd_done_ff  <= 1'b0;
      data_done_ff <= 1'b0;
      over_ff      <= 1'b0;
      wr_data_ff   <= 24'h000000;
    end else begin
      if (bit_cnt_ff != 6'h3f) begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
      shift_ff <= {shift_ff[22:0], spi_din};
      if (!cmd_done_ff && bit_cnt_ff == `ASD_CMD_BITS - 6'd1) begin
        cmd_ff      <= {shift_ff[6:0], spi_din};
        cmd_done_ff <= 1'b1;
      end
      if (cmd_done_ff && !data_done_ff && bit_cnt_ff == last_bit) begin
        wr_data_ff   <= {shift_ff[22:0], spi_din};
        data_done_ff <= 1'b1;
      end
      if (data_done_ff) begin
        over_ff <= 1'b1;
      end
    end
  end

  // Drive edge is the falling one
  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      dout_ff    <= 1'b0;
      dout_oe_ff <= 1'b0;
    end else begin
      dout_oe_ff <= 1'b1;
      if (cmd_done_ff && cmd_ff.read && !data_done_ff) begin
        dout_ff <= rd_hold_ff[out_idx];
      end else begin
        dout_ff <= 1'b0;
      end
    end
  end

  assign spi_dout    = dout_ff;
  assign spi_dout_oe = dout_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the system domain

  logic [1:0] cs_sync_ff;
  logic [1:0] cmd_sync_ff;
  logic [1:0] data_sync_ff;
  logic [1:0] over_sync_ff;
  logic       cs_prev_ff;
  logic       cmd_prev_ff;
  logic       data_prev_ff;
  logic       over_prev_ff;
  logic       cs_rise;
  logic       cmd_rise;
  logic       data_rise;
  logic       over_rise;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_sync_ff   <= 2'h3;
      cmd_sync_ff  <= 2'h0;
      data_sync_ff <= 2'h0;
      over_sync_ff <= 2'h0;
      cs_prev_ff   <= 1'b1;
      cmd_prev_ff  <= 1'b0;
      data_prev_ff <= 1'b0;
      over_prev_ff <= 1'b0;
    end else begin
      cs_sync_ff   <= {cs_sync_ff[0], spi_cs_n};
      cmd_sync_ff  <= {cmd_sync_ff[0], cmd_done_ff};
      data_sync_ff <= {data_sync_ff[0], data_done_ff};
      over_sync_ff <= {over_sync_ff[0], over_ff};
      cs_prev_ff   <= cs_sync_ff[1];
      cmd_prev_ff  <= cmd_sync_ff[1];
      data_prev_ff <= data_sync_ff[1];
      over_prev_ff <= over_sync_ff[1];
    end
  end

  assign cs_rise   = cs_sync_ff[1] & ~cs_prev_ff;
  assign cmd_rise  = cmd_sync_ff[1] & ~cmd_prev_ff;
  assign data_rise = data_sync_ff[1] & ~data_prev_ff;
  assign over_rise = over_sync_ff[1] & ~over_prev_ff;

  // Command and data words are stable once their done level has crossed
  logic [5:0] addr;
  logic       addr_ok;
  logic       cmd_go;
  logic       wr_go;
  logic [2:0] idx_cfg;
  logic [2:0] idx_filt;
  logic [2:0] idx_off;
  logic [2:0] idx_gain;

  assign addr     = cmd_ff.target_reg_index;
  assign addr_ok  = (addr <= `ASD_ADDR_LAST);
  assign cmd_go   = cmd_rise & ~cmd_ff.write_gate;
  assign wr_go    = data_rise & ~cmd_ff.write_gate & ~cmd_ff.read & addr_ok & ~serial_blocked;
  assign idx_cfg  = 3'(addr - `ASD_ADDR_CFG_BASE);
  assign idx_filt = (addr == `ASD_ADDR_FILT0) ? 3'h0 : 3'(addr - `ASD_ADDR_FILT_BASE);
  assign idx_off  = 3'(addr - `ASD_ADDR_OFF_BASE);
  assign idx_gain = 3'(addr - `ASD_ADDR_GAIN_BASE);

  ////////////////////////////////////////////////////////////////////////////
  // Setup groups

  asd_pkg::asd_cfg_s  cfg_ff  [NSETUP];
  asd_pkg::asd_filt_s filt_ff [NSETUP];
  logic [23:0]        off_ff  [NSETUP];
  logic [23:0]        gain_ff [NSETUP];

  genvar g;
  generate
    for (g = 0; g < NSETUP; g++) begin : g_setup
      localparam logic [5:0] A_CFG  = 6'(`ASD_ADDR_CFG_BASE + g);
      localparam logic [5:0] A_FILT = (g == 0) ? `ASD_ADDR_FILT0 : 6'(`ASD_ADDR_FILT_BASE + g);
      localparam logic [5:0] A_OFF  = 6'(`ASD_ADDR_OFF_BASE + g);
      localparam logic [5:0] A_GAIN = 6'(`ASD_ADDR_GAIN_BASE + g);

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          cfg_ff[g]  <= `ASD_CFG_RST;
          filt_ff[g] <= `ASD_FILT_RST;
        end else begin
          if (wr_go && addr == A_CFG) begin
            cfg_ff[g] <= wr_data_ff[15:0] & `ASD_CFG_WMASK;
          end
          if (wr_go && addr == A_FILT) begin
            filt_ff[g] <= wr_data_ff & `ASD_FILT_WMASK;
          end
        end
      end

      // Calibration result beats a host write landing in the same cycle
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          off_ff[g] <= `ASD_OFF_RST;
        end else if (cal_offset_load && cal_setup == 3'(g)) begin
          off_ff[g] <= cal_value;
        end else if (wr_go && addr == A_OFF) begin
          off_ff[g] <= wr_data_ff;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          gain_ff[g] <= GAIN_TRIM;
        end else if (cal_gain_load && cal_setup == 3'(g)) begin
          gain_ff[g] <= cal_value;
        end else if (wr_go && addr == A_GAIN) begin
          gain_ff[g] <= wr_data_ff;
        end
      end
    end
  endgenerate

  asd_pkg::asd_cfg_s  sel_cfg_ff;
  asd_pkg::asd_filt_s sel_filt_ff;
  logic [23:0]        sel_off_ff;
  logic [23:0]        sel_gain_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_cfg_ff  <= `ASD_CFG_RST;
      sel_filt_ff <= `ASD_FILT_RST;
      sel_off_ff  <= `ASD_OFF_RST;
      sel_gain_ff <= GAIN_TRIM;
    end else begin
      sel_cfg_ff  <= cfg_ff[active_setup];
      sel_filt_ff <= filt_ff[active_setup];
      sel_off_ff  <= off_ff[active_setup];
      sel_gain_ff <= gain_ff[active_setup];
    end
  end

  assign sel_cfg    = sel_cfg_ff;
  assign sel_filt   = sel_filt_ff;
  assign sel_offset = sel_off_ff;
  assign sel_gain   = sel_gain_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Converter control

  asd_pkg::asd_ctrl_s ctrl_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_ff <= `ASD_CTRL_RST;
    end else if (wr_go && addr == `ASD_ADDR_CTRL) begin
      ctrl_ff <= wr_data_ff[15:0] & `ASD_CTRL_WMASK;
    end
  end

  assign ctrl = ctrl_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostics

  logic [23:0] diag_en_ff;
  logic [23:0] fault_ff;
  logic [7:0]  tally_ff;
  logic        fault_sum_ff;
  logic        cmd_seen_ff;
  logic        data_seen_ff;
  logic [23:0] fault_set;
  logic [23:0] fault_clr;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diag_en_ff <= `ASD_DIAG_EN_RST;
    end else if (wr_go && addr == `ASD_ADDR_DIAG_EN) begin
      diag_en_ff <= wr_data_ff & `ASD_DIAG_EN_WMASK;
    end
  end

  // Remembers what the frame delivered, for the clock-count check at its end
  always_ff @(posedge clk_sys) begin
    if (rst || cs_rise) begin
      cmd_seen_ff  <= 1'b0;
      data_seen_ff <= 1'b0;
    end else begin
      if (cmd_go) begin
        cmd_seen_ff <= 1'b1;
      end
      if (data_rise) begin
        data_seen_ff <= 1'b1;
      end
    end
  end

  always_comb begin
    fault_set = diag_evt;
    fault_set[`ASD_BIT_IGNORE]   = serial_blocked;
    fault_set[`ASD_BIT_READ]     = cmd_go & cmd_ff.read & ~addr_ok;
    fault_set[`ASD_BIT_WRITE]    = cmd_go & ~cmd_ff.read & ~addr_ok;
    fault_set[`ASD_BIT_SCLK_CNT] = over_rise | (cs_rise & cmd_seen_ff & ~data_seen_ff);
    fault_set = fault_set & diag_en_ff & `ASD_FAULT_MASK;
  end

  // Reading the fault flags clears them; the serial-blocked bit simply follows its level
  assign fault_clr = (cmd_go && cmd_ff.read && addr == `ASD_ADDR_FAULT) ? 24'hffffff :
                     (24'h000001 << `ASD_BIT_IGNORE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_ff <= `ASD_FAULT_RST;
    end else begin
      fault_ff <= (fault_ff & ~fault_clr) | fault_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_sum_ff <= 1'b0;
    end else begin
      fault_sum_ff <= |(fault_ff & diag_en_ff);
    end
  end

  // Counts wrap; software measures the delta between two reads
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tally_ff <= `ASD_TALLY_RST;
    end else if (diag_en_ff[`ASD_BIT_TALLY_EN]) begin
      tally_ff <= tally_ff + 8'h01;
    end
  end

  assign diag_enables  = diag_en_ff;
  assign fault_summary = fault_sum_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [23:0] rd_word;

  always_comb begin
    rd_word = 24'h000000;
    if (addr == `ASD_ADDR_STATUS) begin
      rd_word[`ASD_STATUS_ERR_BIT] = fault_sum_ff;
    end else if (addr == `ASD_ADDR_CTRL) begin
      rd_word = {8'h00, ctrl_ff};
    end else if (addr == `ASD_ADDR_FAULT) begin
      rd_word = fault_ff;
    end else if (addr == `ASD_ADDR_DIAG_EN) begin
      rd_word = diag_en_ff;
    end else if (addr == `ASD_ADDR_TALLY) begin
      rd_word = {16'h0000, tally_ff};
    end else if (addr >= `ASD_ADDR_CFG_BASE && addr <= `ASD_ADDR_CFG_LAST) begin
      rd_word = {8'h00, cfg_ff[idx_cfg]};
    end else if (addr >= `ASD_ADDR_FILT_LO && addr <= `ASD_ADDR_FILT0) begin
      rd_word = filt_ff[idx_filt];
    end else if (addr >= `ASD_ADDR_OFF_BASE && addr <= `ASD_ADDR_OFF_LAST) begin
      rd_word = off_ff[idx_off];
    end else if (addr >= `ASD_ADDR_GAIN_BASE && addr <= `ASD_ADDR_LAST) begin
      rd_word = gain_ff[idx_gain];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_hold_ff <= 24'h000000;
    end else if (cmd_go && cmd_ff.read) begin
      rd_hold_ff <= rd_word;
    end
  end

endmodule
